// File: cs_decoder_pkg.sv
// constants for the programmable chip-select decoder
package cs_decoder_pkg;
	// control block offsets of the select registers
	localparam logic [7:0] upper_region_off = 8'ha0;
	localparam logic [7:0] lower_region_off = 8'ha2;
	localparam logic [7:0] periph_base_off = 8'ha4;
	localparam logic [7:0] midrange_base_off = 8'ha6;
	localparam logic [7:0] midrange_size_off = 8'ha8;
	// field positions
	localparam int rdy_lsb = 0;
	localparam int rdy_w = 3;
	localparam int mid_size_lsb = 8;
	localparam int mid_size_w = 7;
	localparam int mid_base_lsb = 9;
	localparam int space_bit = 6;
	localparam int line_cnt_bit = 7;
	localparam int upper_lim_lsb = 6;
	localparam int periph_base_lsb = 6;
	// reset values of the configuration registers
	localparam logic [15:0] upper_region_rst = 16'hfffb;
	localparam logic [15:0] lower_region_rst = 16'h0000;
	localparam logic [15:0] cfg_undef_rst = 16'h0000;
	// output latency in cycles from a registered cycle request
	localparam int sel_latency = 1;
endpackage

// File: cs_region_match.sv
// one-hot sized block match with quarter split for the midrange selects
`timescale 1ns/100ps
module cs_region_match #(
	parameter int ADDR_W = 20
) (
	// cycle address
	input wire logic [ADDR_W-1:0] addr_in,
	// block base, A19-A13
	input wire logic [6:0] base_in,
	// one-hot size, 8k << n
	input wire logic [6:0] size_in,
	// results
	output logic hit_out,
	output logic [1:0] quarter_out
);
	logic [6:0] high_addr;
	logic [6:0] base_mask;
	logic [3:0] bit_pos;
	// the block field and quarter split assume a 20-bit address space
	if (ADDR_W != 20) begin : g_bad_width
		$error("cs_region_match supports only a 20-bit address");
	end
	assign high_addr = addr_in[19:13];
	// mask keeps address bits above the block size
	assign base_mask = ~(size_in - 7'h01);
	assign hit_out = ((high_addr & base_mask) == (base_in & base_mask))
		&& (size_in != 7'h00);
	always_comb begin
		bit_pos = 4'h0;
		for (int i = 0; i < 7; i++) begin
			if (size_in[i]) begin
				bit_pos = 4'(i);
			end
		end
	end
	// quarter index: the two address bits below the block size bit
	assign quarter_out = addr_in[5'(12) + 5'(bit_pos) -: 2];
endmodule

// File: cs_decoder.sv
// programmable chip-select decoder with control block registers
`timescale 1ns/100ps
module cs_decoder (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// processor bus cycle, cpu or dma
	input wire logic cyc_valid_in,
	input wire logic cyc_is_mem_in,
	input wire logic [19:0] cyc_addr_in,
	// control block access
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_off_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	// chip selects, active low
	output logic upper_mem_select_n_out,
	output logic lower_mem_select_n_out,
	output logic [3:0] mid_mem_select_n_out,
	output logic [6:0] periph_select_n_out,
	// ready mode of the selected region
	output logic [2:0] ready_wait_mode_out
);
	logic [15:0] upper_region_config_r;
	logic [15:0] lower_region_config_r;
	logic [15:0] periph_base_config_r;
	logic [15:0] midrange_base_config_r;
	logic [15:0] midrange_size_periph_config_r;
	logic mid_base_seen_r;
	logic mid_size_seen_r;
	logic periph_base_seen_r;
	logic upper_n_r;
	logic lower_n_r;
	logic [3:0] mid_n_r;
	logic [6:0] periph_n_r;
	logic [2:0] rdy_r;
	logic [15:0] rdata_r;
	logic [3:0] mid_n_nxt;
	logic [6:0] periph_n_nxt;
	logic [2:0] rdy_nxt;

	function automatic logic hit_reg(input logic [7:0] off,
		input logic [7:0] want);
		hit_reg = (off == want);
	endfunction

	logic acc;
	logic sel_upper_reg;
	logic sel_lower_reg;
	logic sel_pbase_reg;
	logic sel_mbase_reg;
	logic sel_msize_reg;
	assign acc = reg_wr_in || reg_rd_in;
	assign sel_upper_reg = hit_reg(reg_off_in, cs_decoder_pkg::upper_region_off);
	assign sel_lower_reg = hit_reg(reg_off_in, cs_decoder_pkg::lower_region_off);
	assign sel_pbase_reg = hit_reg(reg_off_in, cs_decoder_pkg::periph_base_off);
	assign sel_mbase_reg = hit_reg(reg_off_in,
		cs_decoder_pkg::midrange_base_off);
	assign sel_msize_reg = hit_reg(reg_off_in,
		cs_decoder_pkg::midrange_size_off);

	// upper region: lower limit from bits 13:6 give a17:a10, top fixed
	logic [9:0] upper_lim;
	logic upper_hit;
	assign upper_lim = {2'b11, upper_region_config_r[13:6]};
	assign upper_hit = cyc_is_mem_in
		&& (cyc_addr_in[19:10] >= upper_lim);

	// lower region: size from bits 13:6 as a17:a10 ceiling, base zero
	logic [9:0] lower_lim;
	logic lower_hit;
	assign lower_lim = {2'b00, lower_region_config_r[13:6]};
	assign lower_hit = cyc_is_mem_in && (cyc_addr_in[19:10] <= lower_lim)
		&& (lower_region_config_r[13:6] != 8'h00);

	// midrange block
	logic mid_hit;
	logic [1:0] mid_q;
	logic mid_live;
	cs_region_match #(.ADDR_W(20)) u_mid (
		.addr_in(cyc_addr_in),
		.base_in(midrange_base_config_r[15:9]),
		.size_in(midrange_size_periph_config_r[14:8]),
		.hit_out(mid_hit),
		.quarter_out(mid_q)
	);
	assign mid_live = mid_base_seen_r && mid_size_seen_r;

	// peripheral block: seven 128-byte blocks above a 1k base
	logic p_space;
	logic p_seven;
	logic [9:0] p_base;
	logic p_space_ok;
	logic p_in_block;
	logic [2:0] p_idx;
	logic p_live;
	assign p_space = midrange_size_periph_config_r[cs_decoder_pkg::space_bit];
	assign p_seven = midrange_size_periph_config_r[cs_decoder_pkg::line_cnt_bit];
	assign p_base = periph_base_config_r[15:6];
	assign p_space_ok = (cyc_is_mem_in == p_space);
	assign p_in_block = (cyc_addr_in[19:10] == p_base) && p_space_ok;
	assign p_idx = cyc_addr_in[9:7];
	assign p_live = mid_size_seen_r && periph_base_seen_r;

	always_comb begin
		mid_n_nxt = 4'hf;
		periph_n_nxt = 7'h7f;
		rdy_nxt = 3'h0;
		if (cyc_valid_in) begin
			if (upper_hit) begin
				rdy_nxt = upper_region_config_r[2:0];
			end else if (lower_hit) begin
				rdy_nxt = lower_region_config_r[2:0];
			end
			if (mid_live && mid_hit && cyc_is_mem_in) begin
				mid_n_nxt[mid_q] = 1'b0;
				rdy_nxt = midrange_base_config_r[2:0];
			end
			if (p_live && p_in_block && p_idx != 3'h7
				&& (p_seven || p_idx < 3'h5)) begin
				periph_n_nxt[p_idx] = 1'b0;
				if (p_idx >= 3'h4) begin
					rdy_nxt = midrange_size_periph_config_r[2:0];
				end else begin
					rdy_nxt = periph_base_config_r[2:0];
				end
			end
		end
		if (p_live && !p_seven) begin
			periph_n_nxt[5] = !cyc_addr_in[1];
			periph_n_nxt[6] = !cyc_addr_in[2];
		end
	end

	logic [15:0] rdata_nxt;
	assign rdata_nxt = sel_upper_reg ? upper_region_config_r :
		sel_lower_reg ? lower_region_config_r :
		sel_pbase_reg ? periph_base_config_r :
		sel_mbase_reg ? midrange_base_config_r :
		sel_msize_reg ? midrange_size_periph_config_r : 16'h0000;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			upper_region_config_r <= cs_decoder_pkg::upper_region_rst;
			lower_region_config_r <= cs_decoder_pkg::lower_region_rst;
			periph_base_config_r <= cs_decoder_pkg::cfg_undef_rst;
			midrange_base_config_r <= cs_decoder_pkg::cfg_undef_rst;
			midrange_size_periph_config_r <= cs_decoder_pkg::cfg_undef_rst;
		end else if (reg_wr_in) begin
			if (sel_upper_reg) begin
				upper_region_config_r <= reg_wdata_in;
			end
			if (sel_lower_reg) begin
				lower_region_config_r <= reg_wdata_in;
			end
			if (sel_pbase_reg) begin
				periph_base_config_r <= reg_wdata_in;
			end
			if (sel_mbase_reg) begin
				midrange_base_config_r <= reg_wdata_in;
			end
			if (sel_msize_reg) begin
				midrange_size_periph_config_r <= reg_wdata_in;
			end
		end
	end

	// access flags: any read or write counts as an access
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			mid_base_seen_r <= 1'b0;
			mid_size_seen_r <= 1'b0;
			periph_base_seen_r <= 1'b0;
		end else if (acc) begin
			mid_base_seen_r <= mid_base_seen_r | sel_mbase_reg;
			mid_size_seen_r <= mid_size_seen_r | sel_msize_reg;
			periph_base_seen_r <= periph_base_seen_r | sel_pbase_reg;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			upper_n_r <= 1'b1;
			lower_n_r <= 1'b1;
			mid_n_r <= 4'hf;
			periph_n_r <= 7'h7f;
			rdy_r <= 3'h0;
			rdata_r <= 16'h0000;
		end else begin
			upper_n_r <= !(cyc_valid_in && upper_hit);
			lower_n_r <= !(cyc_valid_in && lower_hit);
			mid_n_r <= mid_n_nxt;
			periph_n_r <= periph_n_nxt;
			rdy_r <= rdy_nxt;
			rdata_r <= reg_rd_in ? rdata_nxt : 16'h0000;
		end
	end

	assign upper_mem_select_n_out = upper_n_r;
	assign lower_mem_select_n_out = lower_n_r;
	assign mid_mem_select_n_out = mid_n_r;
	assign periph_select_n_out = periph_n_r;
	assign ready_wait_mode_out = rdy_r;
	assign reg_rdata_out = rdata_r;

	property p_mid_quiet;
		@(posedge core_clk_in) disable iff (reset_in)
		!mid_live |=> mid_mem_select_n_out == 4'hf;
	endproperty
	a_mid_quiet: assert property (p_mid_quiet) else $error("mid early");

	property p_periph_quiet;
		@(posedge core_clk_in) disable iff (reset_in)
		!p_live |=> periph_select_n_out == 7'h7f;
	endproperty
	a_periph_quiet: assert property (p_periph_quiet) else $error("pcs early");

	property p_upper_top;
		@(posedge core_clk_in) disable iff (reset_in)
		(cyc_valid_in && cyc_is_mem_in && cyc_addr_in == 20'hfffff)
		|=> !upper_mem_select_n_out;
	endproperty
	a_upper_top: assert property (p_upper_top) else $error("top missed");

	property p_mid_onehot;
		@(posedge core_clk_in) disable iff (reset_in)
		1'b1 |=> $countones(~mid_mem_select_n_out) <= 1;
	endproperty
	a_mid_onehot: assert property (p_mid_onehot) else $error("two mid");

	property p_mid_idle;
		@(posedge core_clk_in) disable iff (reset_in)
		!cyc_valid_in |=> mid_mem_select_n_out == 4'hf;
	endproperty
	a_mid_idle: assert property (p_mid_idle) else $error("mid idle");

	property p_periph_space;
		@(posedge core_clk_in) disable iff (reset_in)
		(cyc_valid_in && !p_space_ok) |=>
		periph_select_n_out[4:0] == 5'h1f;
	endproperty
	a_periph_space: assert property (p_periph_space) else $error("space");

	property p_latched_a;
		@(posedge core_clk_in) disable iff (reset_in)
		(p_live && !p_seven) |=>
		periph_select_n_out[6:5] == ~$past({cyc_addr_in[2], cyc_addr_in[1]});
	endproperty
	a_latched_a: assert property (p_latched_a) else $error("a1a2");

	property p_mid_rdy;
		@(posedge core_clk_in) disable iff (reset_in)
		(mid_live && mid_hit && cyc_valid_in && cyc_is_mem_in && !(p_live
		&& p_in_block)) |=> ready_wait_mode_out ==
		$past(midrange_base_config_r[2:0]);
	endproperty
	a_mid_rdy: assert property (p_mid_rdy) else $error("mid rdy");

	property p_upper_idle;
		@(posedge core_clk_in) disable iff (reset_in)
		!cyc_valid_in |=> upper_mem_select_n_out;
	endproperty
	a_upper_idle: assert property (p_upper_idle) else $error("uidle");

	property p_periph_idle;
		@(posedge core_clk_in) disable iff (reset_in)
		!cyc_valid_in |=> periph_select_n_out[4:0] == 5'h1f;
	endproperty
	a_periph_idle: assert property (p_periph_idle) else $error("pidle");

	property p_mid_io;
		@(posedge core_clk_in) disable iff (reset_in)
		(cyc_valid_in && !cyc_is_mem_in) |=> mid_mem_select_n_out == 4'hf;
	endproperty
	a_mid_io: assert property (p_mid_io) else $error("mid io");

	// selects 4 to 6 take their ready mode from the size register
	property p_periph_rdy;
		@(posedge core_clk_in) disable iff (reset_in)
		(cyc_valid_in && p_live && p_in_block && p_idx >= 3'h4
		&& (p_idx == 3'h4 || (p_seven && p_idx != 3'h7)))
		|=> ready_wait_mode_out ==
		$past(midrange_size_periph_config_r[2:0]);
	endproperty
	a_periph_rdy: assert property (p_periph_rdy) else $error("prdy");

	c_mid: cover property (@(posedge core_clk_in) !mid_mem_select_n_out[3]);
	c_pcs: cover property (@(posedge core_clk_in) !periph_select_n_out[4]);
	c_up: cover property (@(posedge core_clk_in) !upper_mem_select_n_out);
	c_latch: cover property (@(posedge core_clk_in) p_live && !p_seven);
endmodule

// File: cs_targets.sv
// partner model: the memories and peripherals that answer to the selects
`timescale 1ns/100ps
module cs_targets (
	// selects from the decoder, active low
	input wire logic upper_n_in,
	input wire logic lower_n_in,
	input wire logic [3:0] mid_n_in,
	input wire logic [4:0] periph_n_in,
	// number of devices driving the data bus at once
	output logic [3:0] active_count_out
);
	// each selected device drives the bus, so more than one is a clash
	assign active_count_out = 4'(!upper_n_in) + 4'(!lower_n_in)
		+ 4'($countones(~mid_n_in)) + 4'($countones(~periph_n_in));
endmodule

// File: cs_decoder_bench.sv
// self-checking bench for the chip-select decoder with a reference model
`timescale 1ns/100ps
module cs_decoder_bench;
	logic core_clk_in = 0;
	logic reset_in = 1;
	logic cyc_valid_in = 0;
	logic cyc_is_mem_in = 0;
	logic reg_wr_in = 0;
	logic reg_rd_in = 0;
	logic [19:0] cyc_addr_in = 0;
	logic [7:0] reg_off_in = 0;
	logic [15:0] reg_wdata_in = 0;
	logic [15:0] reg_rdata_out;
	logic upper_n, lower_n;
	logic [3:0] mid_n, cnt;
	logic [6:0] per_n;
	logic [2:0] rdy;
	logic [15:0] cfg [5] = '{cs_decoder_pkg::upper_region_rst, 0, 0, 0, 0};
	bit acc [5];
	logic [31:0] seed = 32'h8496;
	logic [31:0] r;
	int fail_count = 0;
	int cmp_count = 0;
	int pb_m;
	logic [15:0] tbl [9] = '{16'hfff8, 16'hffb8, 16'hff38, 16'hfe38,
		16'hfc38, 16'hf838, 16'hf038, 16'he038, 16'hc038};
	always #10 core_clk_in = ~core_clk_in;
	cs_decoder uut (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.cyc_valid_in(cyc_valid_in), .cyc_is_mem_in(cyc_is_mem_in),
		.cyc_addr_in(cyc_addr_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_off_in(reg_off_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.upper_mem_select_n_out(upper_n), .lower_mem_select_n_out(lower_n),
		.mid_mem_select_n_out(mid_n), .periph_select_n_out(per_n),
		.ready_wait_mode_out(rdy));
	cs_targets targets (.upper_n_in(upper_n), .lower_n_in(lower_n),
		.mid_n_in(mid_n), .periph_n_in(per_n[4:0]),
		.active_count_out(cnt));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [15:0] got, exp, mask);
		cmp_count++;
		if ((got & mask) !== (exp & mask)) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one control block access; a read is checked the cycle after
	task automatic reg_acc(input bit wr, input logic [7:0] off,
		input logic [15:0] d);
		int i;
		bit hit;
		i = (off - 8'ha0) / 2;
		hit = off >= 8'ha0 && off <= 8'ha8 && !off[0];
		reg_wr_in = wr;
		reg_rd_in = !wr;
		reg_off_in = off;
		reg_wdata_in = d;
		@(negedge core_clk_in);
		reg_wr_in = 0;
		reg_rd_in = 0;
		if (hit) acc[i] = 1;
		if (hit && wr) cfg[i] = d;
		if (!wr) check(reg_rdata_out, hit ? cfg[i] : 16'h0, 16'hffff);
		// one idle cycle so the next access never re-raises a strobe
		@(negedge core_clk_in);
	endtask
	// one bus cycle; expected selects come from the model of the rules
	task automatic cyc(input bit v, input logic [19:0] a, input bit mem);
		int i, tot, mb, pb;
		logic [15:0] e, m;
		e = 16'hffff;
		m = 16'h1fff;
		tot = 32'h2000 * cfg[4][14:8];
		mb = {cfg[3][15:9], 13'h0};
		pb = {cfg[2][15:6], 10'h0};
		i = (a - pb) / 128;
		cyc_valid_in = v;
		cyc_is_mem_in = mem;
		cyc_addr_in = a;
		if (v && mem && a[19:10] >= {2'b11, cfg[0][13:6]}) begin
			e[0] = 0;
			e[15:13] = cfg[0][2:0];
			m = '1;
		end
		if (v && acc[3] && acc[4] && mem && a >= mb && a < mb + tot) begin
			e[2 + (a - mb) / (tot / 4)] = 0;
			e[15:13] = cfg[3][2:0];
			m = '1;
		end
		if (v && acc[2] && acc[4] && mem == cfg[4][6] && a >= pb
			&& a < pb + 1024) begin
			if (i < 5 || (i < 7 && cfg[4][7])) begin
				e[6 + i] = 0;
				e[15:13] = i < 4 ? cfg[2][2:0] : cfg[4][2:0];
				m = '1;
			end
			if (!cfg[4][7]) e[12:11] = ~a[2:1];
		end else if (!cfg[4][7]) m[12:11] = 0;
		@(negedge core_clk_in);
		check({rdy, per_n, mid_n, lower_n, upper_n}, e, m);
		check({15'h0, cnt <= 1}, 16'h1, 16'h1);
	endtask
	task automatic traffic(input int k);
		int j;
		logic [19:0] a;
		bit mem;
		for (j = 0; j < k; j++) begin
			r = rnd();
			mem = r[1:0] == 0 || r[30];
			a = r[1:0] == 0 ? {2'b11, r[19:2]} : r[1:0] == 1 ?
				20'h80000 + r[31:14] : r[1:0] == 2 ? pb_m + r[12:3] : r[23:4];
			if (k < 40) a = r[12:0];
			if (!mem) a[19:16] = 0;
			cyc(r[29:27] != 0, a, mem);
		end
	endtask
	initial begin
		#1_000_000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(negedge core_clk_in);
		reset_in = 0;
		reg_acc(0, 8'ha0, 0);
		reg_acc(0, 8'ha2, 0);
		reg_acc(0, 8'haa, 0);
		reg_acc(1, 8'haa, 16'h1234);
		reg_acc(0, 8'haa, 0);
		// size set, block at zero, but neither base register touched yet
		reg_acc(1, 8'ha8, 16'h01c0);
		traffic(30);
		reg_acc(1, 8'ha4, 16'h0001);
		traffic(30);
		$display("test gating done");
		for (int n = 0; n < 9; n++) begin
			pb_m = n[0] ? 32'h7fc00 : 32'h00400;
			reg_acc(1, 8'ha0, tbl[n] | 16'(n % 8));
			reg_acc(1, 8'ha6, (n % 7 == 6 ? 16'h0 : 16'h8000)
				| 16'(7 - n % 8));
			reg_acc(1, 8'ha8, 16'(1 << (8 + n % 7)) | {8'h00, n[1:0], 6'h00}
				| 16'((n + 3) % 8));
			reg_acc(1, 8'ha4, 16'(pb_m >> 4) | 16'((n + 5) % 8));
			for (int k = 0; k < 5; k++) reg_acc(0, 8'ha0 + 8'(2 * k), 0);
			traffic(300);
			$display("test %0d done", n);
		end
		// board setting: every select at zero wait states, i/o peripherals
		pb_m = 32'h0fc00;
		reg_acc(1, 8'ha0, tbl[4]);
		reg_acc(1, 8'ha6, 16'h8000);
		reg_acc(1, 8'ha8, 16'h0880);
		reg_acc(1, 8'ha4, 16'h0fc0);
		traffic(200);
		$display("test zero wait done");
		cyc_valid_in = 0;
		tally_and_finish();
	end
endmodule
